// ===== pkg/exc_ctl_pkg.sv
// Package: field layout, reset values and types for the thread exception control word
package exc_ctl_pkg;
    localparam int WORD_W = 32;
    localparam int IP_W = 32;
    localparam int EXC_W = 16;
    localparam logic [1:0] CTL_OFFSET = 2'h0;
    localparam int MASTER_BIT = 31;
    localparam int SUPPRESS_BIT = 15;
    localparam int BKPT_IDX = 15;
    localparam logic MASTER_RST = 1'b0;
    localparam logic SUPPRESS_RST = 1'b0;
    localparam logic [31:0] IP_RST = 32'h0000_0000;

    // Software access to the control word
    typedef struct packed {
        logic wr;
        logic [WORD_W-1:0] wdata;
    } ctl_wr_s;

    // Redirect request towards the instruction fetch
    typedef struct packed {
        logic valid;
        logic [IP_W-1:0] target;
    } redirect_s;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b01,
        ST_EXCEPT = 2'b10
    } thread_state_e;
endpackage

// ===== logic/thread_exception_control.sv
// Per-thread exception control word with master exception state and breakpoint suppress
`timescale 1ns/10ps
`default_nettype none

module thread_exception_control
    import exc_ctl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire ctl_wr_s CTL_WRITE,
    output logic [WORD_W-1:0] CTL_RDATA,
    input wire logic [EXC_W-1:0] EXC_EVENT,
    input wire logic [EXC_W-1:0] EXC_ENABLE,
    input wire logic BKPT_HIT,
    input wire logic [IP_W-1:0] CURRENT_IP,
    input wire logic [IP_W-1:0] SYSTEM_ROUTINE_ENTRY_POINTER,
    output redirect_s REDIRECT,
    output logic [IP_W-1:0] SAVED_APPLICATION_POINTER,
    output logic BKPT_SUPPRESSED
);
    // Registered thread state and control bits
    thread_state_e state_r;
    thread_state_e state_nxt;
    logic suppress_r;
    logic suppress_nxt;
    logic suppressed_r;
    logic [IP_W-1:0] aip_r;
    redirect_s redirect_r;
    redirect_s redirect_nxt;

    // State decode; the master bit is simply the exception state
    wire logic in_exc = (state_r == ST_EXCEPT);
    wire logic in_normal = (state_r == ST_NORMAL);

    // Software write decode, one field at a time
    wire logic sw_write = CTL_WRITE.wr;
    wire logic sw_master = CTL_WRITE.wdata[MASTER_BIT];
    wire logic sw_suppress = CTL_WRITE.wdata[SUPPRESS_BIT];
    // A write of 1 to the master bit is never decoded into anything
    wire logic sw_clear = sw_write && !sw_master;

    // Suppress only counts in normal state with breakpoints enabled
    wire logic bkpt_en = EXC_ENABLE[BKPT_IDX];
    wire logic supp_active = in_normal && bkpt_en && suppress_r;
    wire logic bkpt_swallow = supp_active && BKPT_HIT;
    wire logic suppressed_nxt = bkpt_swallow;

    // Event lines after breakpoint qualification and per-exception enables
    wire logic [EXC_W-1:0] raw_events;
    wire logic [EXC_W-1:0] live_events;

    // Per-exception qualification; the breakpoint slot ignores its event input
    genvar e;
    generate
        for (e = 0; e < EXC_W; e = e + 1)
        begin : g_event
            if (e == BKPT_IDX)
            begin : g_bkpt
                // A suppressed hit never reaches the trap logic
                assign raw_events[e] = BKPT_HIT && !supp_active;
            end
            else
            begin : g_plain
                assign raw_events[e] = EXC_EVENT[e];
            end
            // A disabled exception still happens but does not jump
            assign live_events[e] = raw_events[e] && EXC_ENABLE[e];
        end
    endgenerate

    // Taking an exception; nested ones while handling are dropped, not queued
    wire logic take_exc = in_normal && (|live_events);
    // Clearing a master bit that is already 0 causes no return jump
    wire logic do_return = in_exc && sw_clear;
    // Pointer saved on entry so the return needs no software copy
    wire logic [IP_W-1:0] aip_nxt = take_exc ? CURRENT_IP : aip_r;

    // Next state and redirect; the case keeps the one-hot decode explicit
    always_comb
    begin
        state_nxt = state_r;
        redirect_nxt = '{valid: 1'b0, target: redirect_r.target};
        case (state_r)
            ST_NORMAL:
            begin
                if (take_exc)
                begin
                    state_nxt = ST_EXCEPT;
                    redirect_nxt = '{valid: 1'b1, target: SYSTEM_ROUTINE_ENTRY_POINTER};
                end
            end
            ST_EXCEPT:
            begin
                // Stays here until software clears bit 31
                if (do_return)
                begin
                    state_nxt = ST_NORMAL;
                    redirect_nxt = '{valid: 1'b1, target: aip_r};
                end
            end
            default:
            begin
                // Illegal code: fall back to normal state without a jump
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    // Suppress bit: every word write loads it, a swallowed breakpoint clears it
    always_comb
    begin
        suppress_nxt = suppress_r;
        if (sw_write)
        begin
            suppress_nxt = sw_suppress;
        end
        // Hardware clear wins over a same-cycle write so the next hit traps
        if (bkpt_swallow)
        begin
            suppress_nxt = 1'b0;
        end
    end

    // Thread state; reset leaves the master bit at 0
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_r <= ST_NORMAL;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Breakpoint suppress bit
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            suppress_r <= SUPPRESS_RST;
        end
        else
        begin
            suppress_r <= suppress_nxt;
        end
    end

    // One-cycle report of a swallowed breakpoint
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            suppressed_r <= 1'b0;
        end
        else
        begin
            suppressed_r <= suppressed_nxt;
        end
    end

    // Redirect request; the target holds until the next jump
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            redirect_r <= '{valid: 1'b0, target: IP_RST};
        end
        else
        begin
            redirect_r <= redirect_nxt;
        end
    end

    // Saved application pointer
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            aip_r <= IP_RST;
        end
        else
        begin
            aip_r <= aip_nxt;
        end
    end

    // Read view built bit by bit: two live fields, every reserved bit reads 0
    wire logic [WORD_W-1:0] rdata_view;
    genvar b;
    generate
        for (b = 0; b < WORD_W; b = b + 1)
        begin : g_rbit
            if (b == MASTER_BIT)
            begin : g_master
                assign rdata_view[b] = in_exc;
            end
            else if (b == SUPPRESS_BIT)
            begin : g_suppress
                assign rdata_view[b] = suppress_r;
            end
            else
            begin : g_reserved
                // Reserved bits hold no storage, so stray writes cannot leak back
                assign rdata_view[b] = 1'b0;
            end
        end
    endgenerate

    // Outputs straight from the registers above
    assign CTL_RDATA = rdata_view;
    assign REDIRECT = redirect_r;
    assign SAVED_APPLICATION_POINTER = aip_r;
    assign BKPT_SUPPRESSED = suppressed_r;
endmodule // thread_exception_control

`default_nettype wire

// ===== verification/thread_exception_control_chk.sv
// Checker for the thread exception control word
`timescale 1ns/10ps
`default_nettype none
module thread_exception_control_chk
    import exc_ctl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire ctl_wr_s CTL_WRITE,
    input wire logic [31:0] CTL_RDATA,
    input wire logic [15:0] EXC_EVENT,
    input wire logic [15:0] EXC_ENABLE,
    input wire logic BKPT_HIT,
    input wire logic [31:0] CURRENT_IP,
    input wire redirect_s REDIRECT,
    input wire logic [31:0] SAVED_APPLICATION_POINTER,
    input wire logic BKPT_SUPPRESSED
);
    // Master state, enabled non-breakpoint event, enabled breakpoint
    wire m = CTL_RDATA[31];
    wire ev = |(EXC_EVENT[14:0] & EXC_ENABLE[14:0]);
    wire bk = BKPT_HIT & EXC_ENABLE[15];
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_exc; !m && ev; endsequence
    sequence s_clr; m && CTL_WRITE.wr && !CTL_WRITE.wdata[31]; endsequence
    a_reserved_zero: assert property ((CTL_RDATA & 32'h7FFF_7FFF) == 32'h0) else $error("reserved set");
    a_exc_entry: assert property (s_exc |=> m && REDIRECT.valid) else $error("no entry");
    a_set_ignored: assert property (m && CTL_WRITE.wr && CTL_WRITE.wdata[31] |=> m) else $error("set took");
    a_return_app: assert property (s_clr |=> (!m && REDIRECT.valid) ##1 (m || !REDIRECT.valid)) else $error("no return");
    a_return_target: assert property (s_clr |=> REDIRECT.target == $past(SAVED_APPLICATION_POINTER))
        else $error("bad return target");
    a_pointer_save: assert property (s_exc |=> SAVED_APPLICATION_POINTER == $past(CURRENT_IP))
        else $error("pointer not saved");
    a_stay_clear: assert property (!m && !ev && !bk |=> !m) else $error("master rose");
    a_bkpt_swallow: assert property (!m && !ev && CTL_RDATA[15] && bk |=> BKPT_SUPPRESSED && !CTL_RDATA[15])
        else $error("not swallowed");
    a_bkpt_trap: assert property (!m && !CTL_RDATA[15] && bk |=> m) else $error("no trap");
    a_supp_ignored: assert property (BKPT_HIT && (m || !EXC_ENABLE[15]) |=> !BKPT_SUPPRESSED) else $error("bad swallow");
endmodule // thread_exception_control_chk
bind thread_exception_control thread_exception_control_chk thread_exception_control_chk_inst (.*);
`default_nettype wire

// ===== verification/test_thread_exception_control.sv
// Testbench for the thread exception control word
`timescale 1ns/10ps
`default_nettype none
module test_thread_exception_control;
    import exc_ctl_pkg::*;
    logic CLK = 1'b0, RST = 1'b1, BKPT_HIT = 1'b0, BKPT_SUPPRESSED;
    ctl_wr_s CTL_WRITE = '0;
    logic [15:0] EXC_EVENT = '0, EXC_ENABLE = 16'h7FFF;
    logic [31:0] CURRENT_IP = '0, SYSTEM_ROUTINE_ENTRY_POINTER = 32'hC0DE_0100, SAVED_APPLICATION_POINTER, CTL_RDATA;
    redirect_s REDIRECT;
    int errors = 0, compares = 0;
    always #4 CLK = ~CLK;
    thread_exception_control thread_exception_control_inst (
        .CLK(CLK),
        .RST(RST),
        .CTL_WRITE(CTL_WRITE),
        .CTL_RDATA(CTL_RDATA),
        .EXC_EVENT(EXC_EVENT),
        .EXC_ENABLE(EXC_ENABLE),
        .BKPT_HIT(BKPT_HIT),
        .CURRENT_IP(CURRENT_IP),
        .SYSTEM_ROUTINE_ENTRY_POINTER(SYSTEM_ROUTINE_ENTRY_POINTER),
        .REDIRECT(REDIRECT),
        .SAVED_APPLICATION_POINTER(SAVED_APPLICATION_POINTER),
        .BKPT_SUPPRESSED(BKPT_SUPPRESSED)
    );
    task automatic chk(input logic [33:0] s, e);
        compares++;
        if (s !== e) errors++;
        if (s !== e) $display("ERROR %0t: got %h want %h", $time, s, e);
    endtask
    // One request cycle; results settle one edge later
    task automatic step(input logic [15:0] ev, input logic bk, wr, input logic [31:0] wd);
        @(posedge CLK);
        {EXC_EVENT, BKPT_HIT, CTL_WRITE} <= {ev, bk, wr, wd};
        @(posedge CLK);
        {EXC_EVENT, BKPT_HIT, CTL_WRITE} <= '0;
        #1;
    endtask
    task automatic conclude;
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        step(16'h0, 1'b0, 1'b1, 32'h0);
        chk(CTL_RDATA, 32'h0);
        // Every non-breakpoint exception: enter, refuse set and nesting, return
        for (int i = 0; i < 15; i++)
        begin
            @(posedge CLK) CURRENT_IP <= {16'hA5A5, 16'(i)};
            step(16'h1 << i, 1'b0, 1'b0, 32'h0);
            chk({CTL_RDATA[31], REDIRECT}, {2'b11, 32'hC0DE_0100});
            chk(SAVED_APPLICATION_POINTER, {16'hA5A5, 16'(i)});
            step(16'h1, 1'b0, 1'b1, 32'h8000_0000);
            chk({CTL_RDATA[31], REDIRECT.valid}, 2'b10);
            step(16'h0, 1'b0, 1'b1, 32'h0);
            chk({CTL_RDATA[31], REDIRECT}, {2'b01, 16'hA5A5, 16'(i)});
        end
        // Quiet cycles after the last return keep the master bit clear
        step(16'h0, 1'b0, 1'b0, 32'h0);
        chk({CTL_RDATA[31], REDIRECT.valid}, 2'b00);
        // A disabled exception occurs but does not jump
        @(posedge CLK) EXC_ENABLE <= 16'h7FFE;
        step(16'h1, 1'b0, 1'b0, 32'h0);
        chk({CTL_RDATA[31], REDIRECT.valid}, 2'b00);
        @(posedge CLK) EXC_ENABLE <= 16'h7FFF;
        step(16'h0, 1'b0, 1'b1, 32'h0000_8000);
        step(16'h0, 1'b1, 1'b0, 32'h0);
        chk({BKPT_SUPPRESSED, CTL_RDATA}, {1'b0, 32'h0000_8000});
        @(posedge CLK) EXC_ENABLE <= 16'hFFFF;
        step(16'h0, 1'b1, 1'b0, 32'h0);
        chk({BKPT_SUPPRESSED, REDIRECT.valid, CTL_RDATA}, {2'b10, 32'h0});
        step(16'h0, 1'b1, 1'b0, 32'h0);
        chk(CTL_RDATA, 32'h8000_0000);
        step(16'h0, 1'b0, 1'b1, 32'h8000_8000);
        step(16'h0, 1'b1, 1'b0, 32'h0);
        chk({BKPT_SUPPRESSED, CTL_RDATA}, {1'b0, 32'h8000_8000});
        conclude();
    end
endmodule // test_thread_exception_control
`default_nettype wire
